// *** design/acg_audio_clock_gen.v ***
// audio clock generator: master clock synthesis locked to the field rate,
// bit clock and channel select clock dividers, byte register file.
// assumes register strobes and decoder vref come from logic on mclk;
// the looped-back master clock and expansion vref are asynchronous pins.
`timescale 1ns/1ns
`include "acg_consts.vh"
module acg_audio_clock_gen #(
	parameter ACC_W  = `ACG_ACC_W,
	parameter CORR_W = `ACG_CORR_W
) (
	input  wire       mclk,
	input  wire       resetn,
	input  wire       ce,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       decoder_vref,
	input  wire       expansion_vref_input,
	input  wire       audio_master_clock_input,
	output reg        audio_master_clock,
	output wire       serial_bit_clock,
	output wire       channel_select_clock
);

	// register file
	reg [`ACG_CPF_W-1:0]   cycles_per_field_reg;
	reg [`ACG_NI_W-1:0]    nominal_increment_reg;
	reg [`ACG_RATIO_W-1:0] bit_clock_ratio_reg;
	reg [`ACG_RATIO_W-1:0] channel_clock_ratio_reg;
	reg [`ACG_CTRL_W-1:0]  control_reg;

	wire pll_open_select;
	wire vref_source_select;
	wire channel_clock_edge_select;
	wire bit_clock_edge_select;

	assign pll_open_select           = control_reg[`ACG_CTRL_PLL_OPEN];
	assign vref_source_select        = control_reg[`ACG_CTRL_VREF_SRC];
	assign channel_clock_edge_select = control_reg[`ACG_CTRL_CHAN_EDGE];
	assign bit_clock_edge_select     = control_reg[`ACG_CTRL_BIT_EDGE];

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cycles_per_field_reg    <= {`ACG_CPF_W{1'b0}};
			nominal_increment_reg   <= {`ACG_NI_W{1'b0}};
			bit_clock_ratio_reg     <= `ACG_RST_RATIO;
			channel_clock_ratio_reg <= `ACG_RST_RATIO;
			control_reg             <= `ACG_RST_CTRL;
		end else if (ce && reg_wr) begin
			case (reg_addr)
			`ACG_ADDR_CPF_LOW:
				cycles_per_field_reg[7:0] <= reg_wdata;
			`ACG_ADDR_CPF_MID:
				cycles_per_field_reg[15:8] <= reg_wdata;
			`ACG_ADDR_CPF_HIGH:
				cycles_per_field_reg[17:16] <=
					reg_wdata[`ACG_CPF_HIGH_W-1:0];
			`ACG_ADDR_NI_LOW:
				nominal_increment_reg[7:0] <= reg_wdata;
			`ACG_ADDR_NI_MID:
				nominal_increment_reg[15:8] <= reg_wdata;
			`ACG_ADDR_NI_HIGH:
				nominal_increment_reg[21:16] <=
					reg_wdata[`ACG_NI_HIGH_W-1:0];
			`ACG_ADDR_BIT_DIV:
				bit_clock_ratio_reg <= reg_wdata[`ACG_RATIO_W-1:0];
			`ACG_ADDR_CHAN_DIV:
				channel_clock_ratio_reg <= reg_wdata[`ACG_RATIO_W-1:0];
			`ACG_ADDR_CTRL:
				control_reg <= reg_wdata[`ACG_CTRL_W-1:0];
			default: begin
			end
			endcase
		end
	end

	// read data is registered; unused bits and unmapped addresses read 0
	reg [7:0] rdata_next;
	always @* begin
		rdata_next = 8'h00;
		case (reg_addr)
		`ACG_ADDR_CPF_LOW:  rdata_next = cycles_per_field_reg[7:0];
		`ACG_ADDR_CPF_MID:  rdata_next = cycles_per_field_reg[15:8];
		`ACG_ADDR_CPF_HIGH: rdata_next = {6'h00, cycles_per_field_reg[17:16]};
		`ACG_ADDR_NI_LOW:   rdata_next = nominal_increment_reg[7:0];
		`ACG_ADDR_NI_MID:   rdata_next = nominal_increment_reg[15:8];
		`ACG_ADDR_NI_HIGH:  rdata_next = {2'h0, nominal_increment_reg[21:16]};
		`ACG_ADDR_BIT_DIV:  rdata_next = {2'h0, bit_clock_ratio_reg};
		`ACG_ADDR_CHAN_DIV: rdata_next = {2'h0, channel_clock_ratio_reg};
		`ACG_ADDR_CTRL:     rdata_next = {4'h0, control_reg};
		default:            rdata_next = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (ce && reg_rd)
			reg_rdata <= rdata_next;
	end

	// pin synchronisers; the first stage feeds only the second
	reg amx_s1_reg;
	reg amx_s2_reg;
	reg amx_prev_reg;
	reg xrv_s1_reg;
	reg xrv_s2_reg;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			amx_s1_reg   <= 1'b0;
			amx_s2_reg   <= 1'b0;
			amx_prev_reg <= 1'b0;
			xrv_s1_reg   <= 1'b0;
			xrv_s2_reg   <= 1'b0;
		end else if (ce) begin
			amx_s1_reg   <= audio_master_clock_input;
			amx_s2_reg   <= amx_s1_reg;
			amx_prev_reg <= amx_s2_reg;
			xrv_s1_reg   <= expansion_vref_input;
			xrv_s2_reg   <= xrv_s1_reg;
		end
	end

	wire amx_rise;
	wire amx_fall;
	wire bit_tick;

	assign amx_rise = amx_s2_reg & ~amx_prev_reg;
	assign amx_fall = ~amx_s2_reg & amx_prev_reg;
	assign bit_tick = bit_clock_edge_select ? amx_rise : amx_fall;

	acg_clk_div #(
		.RATIO_W (`ACG_RATIO_W)
	) u_bit_div (
		.mclk    (mclk),
		.resetn  (resetn),
		.ce      (ce),
		.tick    (bit_tick),
		.ratio   (bit_clock_ratio_reg),
		.clk_out (serial_bit_clock)
	);

	reg  bit_prev_reg;
	wire chan_tick;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			bit_prev_reg <= 1'b0;
		else if (ce)
			bit_prev_reg <= serial_bit_clock;
	end

	assign chan_tick = channel_clock_edge_select ?
		(serial_bit_clock & ~bit_prev_reg) :
		(~serial_bit_clock & bit_prev_reg);

	acg_clk_div #(
		.RATIO_W (`ACG_RATIO_W)
	) u_chan_div (
		.mclk    (mclk),
		.resetn  (resetn),
		.ce      (ce),
		.tick    (chan_tick),
		.ratio   (channel_clock_ratio_reg),
		.clk_out (channel_select_clock)
	);

	wire vref_level;
	reg  vref_prev_reg;
	wire vref_pulse;

	assign vref_level = vref_source_select ? xrv_s2_reg : decoder_vref;
	assign vref_pulse = vref_level & ~vref_prev_reg;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			vref_prev_reg <= 1'b0;
		else if (ce)
			vref_prev_reg <= vref_level;
	end

	// master clock synthesis: phase accumulator, msb is the clock
	reg  [ACC_W-1:0]      acc_reg;
	reg  signed [CORR_W-1:0] corr_reg;
	reg  [`ACG_CPF_W-1:0] field_cnt_reg;
	wire [`ACG_NI_W-1:0]  inc_eff;
	wire [ACC_W-1:0]      acc_next;
	wire                  own_rise;

	assign inc_eff  = nominal_increment_reg +
		{{(`ACG_NI_W-CORR_W){corr_reg[CORR_W-1]}}, corr_reg};
	assign acc_next = acc_reg + {{(ACC_W-`ACG_NI_W){1'b0}}, inc_eff};
	assign own_rise = acc_next[ACC_W-1] & ~acc_reg[ACC_W-1];

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc_reg            <= {ACC_W{1'b0}};
			audio_master_clock <= 1'b0;
		end else if (ce) begin
			acc_reg            <= acc_next;
			audio_master_clock <= acc_next[ACC_W-1];
		end
	end

	// saturation limits keep an unreachable cycles-per-field target from running the loop away
	localparam signed [CORR_W-1:0] CORR_MAX = {1'b0, {(CORR_W-1){1'b1}}};
	localparam signed [CORR_W-1:0] CORR_MIN = {1'b1, {(CORR_W-1){1'b0}}};
	localparam signed [CORR_W-1:0] CORR_ONE = {{(CORR_W-1){1'b0}}, 1'b1};

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			field_cnt_reg <= {`ACG_CPF_W{1'b0}};
			corr_reg      <= {CORR_W{1'b0}};
		end else if (ce) begin
			if (vref_pulse)
				field_cnt_reg <= {`ACG_CPF_W{1'b0}};
			else if (own_rise)
				field_cnt_reg <= field_cnt_reg +
					{{(`ACG_CPF_W-1){1'b0}}, 1'b1};
			if (pll_open_select)
				corr_reg <= {CORR_W{1'b0}};
			else if (vref_pulse) begin
				if (field_cnt_reg < cycles_per_field_reg &&
					corr_reg != CORR_MAX)
					corr_reg <= corr_reg + CORR_ONE;
				else if (field_cnt_reg > cycles_per_field_reg &&
					corr_reg != CORR_MIN)
					corr_reg <= corr_reg - CORR_ONE;
			end
		end
	end

endmodule // acg_audio_clock_gen

// *** shared/acg_consts.vh ***
// constants for the audio clock generator: subaddresses, field layout,
// reset values and widths; included by the top design file, defines only
`ifndef ACG_CONSTS_VH
`define ACG_CONSTS_VH

// byte-wide register subaddresses
`define ACG_ADDR_CPF_LOW      8'h30
`define ACG_ADDR_CPF_MID      8'h31
`define ACG_ADDR_CPF_HIGH     8'h32
`define ACG_ADDR_NI_LOW       8'h34
`define ACG_ADDR_NI_MID       8'h35
`define ACG_ADDR_NI_HIGH      8'h36
`define ACG_ADDR_BIT_DIV      8'h38
`define ACG_ADDR_CHAN_DIV     8'h39
`define ACG_ADDR_CTRL         8'h3A

// field widths
`define ACG_CPF_W             18
`define ACG_NI_W              22
`define ACG_RATIO_W           6
`define ACG_CPF_HIGH_W        2
`define ACG_NI_HIGH_W         6

// control register bit positions
`define ACG_CTRL_PLL_OPEN     3
`define ACG_CTRL_VREF_SRC     2
`define ACG_CTRL_CHAN_EDGE    1
`define ACG_CTRL_BIT_EDGE     0
`define ACG_CTRL_W            4

// reset values
`define ACG_RST_BYTE          8'h00
`define ACG_RST_RATIO         6'h00
`define ACG_RST_CTRL          4'h0

// synthesis accumulator and loop correction
`define ACG_ACC_W             24
`define ACG_CORR_W            12

`endif

// *** design/acg_clk_div.v ***
// toggling clock divider: the output flips once per 'ratio' input ticks
// assumes tick is a one-cycle pulse in the mclk domain
`timescale 1ns/1ns
module acg_clk_div #(
	parameter RATIO_W = 6
) (
	input  wire               mclk,
	input  wire               resetn,
	input  wire               ce,
	input  wire               tick,
	input  wire [RATIO_W-1:0] ratio,
	output reg                clk_out
);

	reg  [RATIO_W-1:0] count_reg;
	wire [RATIO_W-1:0] count_next;
	wire               wrap;

	assign count_next = count_reg + {{(RATIO_W-1){1'b0}}, 1'b1};
	// ratio 0 behaves as 1 so the output never stalls
	assign wrap = (count_next >= ratio);

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= {RATIO_W{1'b0}};
			clk_out   <= 1'b0;
		end else if (ce && tick) begin
			if (wrap) begin
				count_reg <= {RATIO_W{1'b0}};
				clk_out   <= ~clk_out;
			end else begin
				count_reg <= count_next;
			end
		end
	end

endmodule // acg_clk_div

// *** tb/acg_checker.sv ***
// checker for the audio clock generator top: register bytes and clock edges
// assumes a bind to acg_audio_clock_gen and one clock domain on mclk
`timescale 1ns/1ns
module acg_checker (
	input wire       mclk,
	input wire       resetn,
	input wire       ce,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       audio_master_clock_input,
	input wire       serial_bit_clock,
	input wire       channel_select_clock
);
	logic [3:0] ctrl_reg;
	logic       rd_ok;
	assign rd_ok = ce && reg_rd;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// shadow of the control byte, so edge checks know the selected edge
	always @(posedge mclk or negedge resetn)
		if (!resetn)
			ctrl_reg <= 4'h0;
		else if (ce && reg_wr && reg_addr == 8'h3A)
			ctrl_reg <= reg_wdata[3:0];
	property p_cpf_hi;
		rd_ok && reg_addr == 8'h32 |=> reg_rdata[7:2] == 6'h00;
	endproperty
	a_cpf_hi: assert property (p_cpf_hi)
		else $error("cycles byte spare bits set");
	property p_ni_hi;
		rd_ok && reg_addr == 8'h36 |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_ni_hi: assert property (p_ni_hi)
		else $error("increment byte spare bits set");
	property p_bdiv;
		(ce && reg_wr && reg_addr == 8'h38) ##1 !reg_wr ##1
		(rd_ok && !reg_wr && reg_addr == 8'h38)
		|=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 3)};
	endproperty
	a_bdiv: assert property (p_bdiv)
		else $error("bit ratio readback wrong");
	property p_cdiv_hi;
		rd_ok && reg_addr == 8'h39 |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_cdiv_hi: assert property (p_cdiv_hi)
		else $error("channel ratio spare bits set");
	property p_ctrl_hi;
		rd_ok && reg_addr == 8'h3A |=> reg_rdata[7:4] == 4'h0;
	endproperty
	a_ctrl_hi: assert property (p_ctrl_hi)
		else $error("control spare bits set");
	property p_hold;
		!rd_ok |=> $stable(reg_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	property p_sbc_edge;
		$changed(serial_bit_clock)
		|-> $past(audio_master_clock_input, 2) == ctrl_reg[0];
	endproperty
	a_sbc_edge: assert property (p_sbc_edge)
		else $error("bit clock moved on wrong master edge");
	property p_csc_edge;
		$changed(channel_select_clock) |-> serial_bit_clock == ctrl_reg[1];
	endproperty
	a_csc_edge: assert property (p_csc_edge)
		else $error("channel clock moved on wrong bit edge");
	c_wr: cover property (ce && reg_wr);
	c_sbc: cover property ($changed(serial_bit_clock));
	c_csc: cover property ($changed(channel_select_clock));
endmodule // acg_checker

bind acg_audio_clock_gen acg_checker chk_u (
	.mclk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .audio_master_clock_input, .serial_bit_clock,
	.channel_select_clock
);

// *** tb/acg_mclk_src.sv ***
// far-side return of the master clock at the looped-back pin
// assumes the bench enables it only while it wants link traffic
`timescale 1ns/1ns
module acg_mclk_src (
	input  wire en,
	output reg  clk_out
);
	// 64 ns period, offset 1 ns from mclk edges; idles low when stopped
	initial begin
		clk_out = 1'b0;
		#1;
		forever begin
			#32;
			clk_out <= en ? ~clk_out : 1'b0;
		end
	end
endmodule // acg_mclk_src

// *** tb/tb.sv ***
// bench for the audio clock generator: registers, dividers, edge
// selects, field lock loop; assumes the bound checker and clock source
`timescale 1ns/1ns
module tb;
	logic       mclk;
	logic       resetn;
	logic       ce;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic       xvref;
	logic       dvref;
	logic       src_en;
	wire  [7:0] reg_rdata;
	wire        amc_in;
	wire        amc;
	wire        sbc;
	wire        csc;
	logic       sbc_q = 1'b0;
	logic       csc_q = 1'b0;
	int         n_sbc = 0;
	int         n_csc = 0;
	int         miscompares = 0;
	int         num_checks = 0;
	int         rt [4] = '{0, 1, 3, 63};
	logic [7:0] ad [11] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
		8'h36, 8'h37, 8'h38, 8'h39, 8'h3A};
	logic [7:0] mk [11] = '{8'hFF, 8'hFF, 8'h03, 8'h00, 8'hFF, 8'hFF,
		8'h3F, 8'h00, 8'h3F, 8'h3F, 8'h0F};
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	acg_audio_clock_gen dut_u (
		.mclk                     (mclk),
		.resetn                   (resetn),
		.ce                       (ce),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.decoder_vref             (dvref),
		.expansion_vref_input     (xvref),
		.audio_master_clock_input (amc_in),
		.audio_master_clock       (amc),
		.serial_bit_clock         (sbc),
		.channel_select_clock     (csc)
	);
	acg_mclk_src src_u (.en(src_en), .clk_out(amc_in));
	always @(posedge mclk) begin
		sbc_q <= sbc;
		csc_q <= csc;
		n_sbc <= n_sbc + (sbc !== sbc_q);
		n_csc <= n_csc + (csc !== csc_q);
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_regs;
		logic [7:0] v;
		for (int i = 0; i < 11; i++) begin
			rd(ad[i], v);
			chk(v, 8'h00, "reset value");
			wr(ad[i], 8'hFF);
			rd(ad[i], v);
			chk(v, mk[i], "readback");
		end
		@(posedge mclk) ce <= 1'b0;
		wr(8'h38, 8'h00);
		ce <= 1'b1;
		rd(8'h38, v);
		chk(v, 8'h3F, "frozen write");
		$display("registers done");
	endtask
	task t_div;
		int s0;
		int c0;
		for (int i = 0; i < 4; i++) begin
			wr(8'h38, 8'(rt[i]));
			wr(8'h39, 8'h01);
			wr(8'h3A, 8'(8 + i));
			s0 = n_sbc;
			c0 = n_csc;
			@(posedge mclk) src_en <= 1'b1;
			repeat ((rt[i] == 0 ? 2 : 2 * rt[i]) * 16) @(posedge mclk);
			src_en <= 1'b0;
			repeat (12) @(posedge mclk);
			chk(8'(n_sbc - s0), 8'h02, "bit clock");
			chk(8'(n_csc - c0), 8'h01, "channel clock");
		end
		$display("dividers done");
	endtask
	task watch_amc(input logic exp);
		logic a0;
		logic seen;
		// the trim and the accumulator settle two edges after a write
		repeat (3) @(posedge mclk);
		#1 a0 = amc;
		seen = 1'b0;
		for (int k = 0; k < 9000 && !seen; k++)
			#4 seen = (amc !== a0);
		chk({7'h00, seen}, {7'h00, exp}, "master clock");
		if (exp && !seen)
			test_done;
	endtask
	task t_pll;
		for (int i = 0; i < 6; i++)
			wr(ad[i], 8'h00);
		wr(8'h36, 8'h20);
		wr(8'h3A, 8'h04);
		// too many cycles per field: correction walks down to its floor
		repeat (2100) begin
			repeat (12) @(posedge mclk);
			xvref <= 1'b1;
			repeat (4) @(posedge mclk);
			xvref <= 1'b0;
		end
		wr(8'h36, 8'h00);
		watch_amc(1'b1);
		wr(8'h3A, 8'h0C);
		watch_amc(1'b0);
		$display("field lock done");
	endtask
	task t_vref;
		wr(8'h30, 8'hFF);
		wr(8'h31, 8'hFF);
		wr(8'h32, 8'h03);
		wr(8'h34, 8'hFF);
		wr(8'h35, 8'hFF);
		wr(8'h36, 8'h3F);
		// decoder source selected: pin pulses must leave the trim alone
		wr(8'h3A, 8'h00);
		repeat (4) begin
			repeat (12) @(posedge mclk);
			xvref <= 1'b1;
			repeat (4) @(posedge mclk);
			xvref <= 1'b0;
		end
		watch_amc(1'b1);
		// one decoder pulse adds one to the all-ones increment: clock stops
		@(posedge mclk) dvref <= 1'b1;
		repeat (4) @(posedge mclk);
		dvref <= 1'b0;
		watch_amc(1'b0);
		$display("vref source done");
	endtask
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		xvref = 1'b0;
		dvref = 1'b0;
		src_en = 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		t_regs;
		t_div;
		t_pll;
		t_vref;
		test_done;
	end
endmodule // tb
